// ==== design/sfd_buf2.sv ====
// two-entry output buffer with valid/ready on both sides
`timescale 1ns/100ps
module sfd_buf2
(
    input logic clk,
    input logic srst,
    input logic in_valid,
    output logic in_ready,
    input sfd_pkg::sfd_word_t in_word,
    output logic out_valid,
    input logic out_ready,
    output sfd_pkg::sfd_word_t out_word
);
    import sfd_pkg::*;

    sfd_word_t mem_r [0:1];
    logic [1:0] cnt_r;
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_word = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end
        else if (push)
        begin
            mem_r[wr_ptr_r] <= in_word;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_r <= 2'h0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= ~wr_ptr_r;
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end
endmodule // sfd_buf2

// ==== design/sfd_filter.sv ====
// sinc/fir decimation filter for the modulator bit stream
// Functional notes
// - first stage is fixed sinc5, decimating by 24, 48 or 64
// - modulator bits are taken once every eight converter clocks
// - rates 38400, 19200, 14400 bypass stage two; output is stage one
// - lower rates: stage two decimates the 14400 sps stage-one stream further
// - output rate is modulator rate divided by A times B
// - stage two is sinc of order one to four from the order field
// - codes 0000..1100 use A 64 and the tabulated B values
// - 1101 is A 64 B 1; 1110 A 48, 1111 A 24; all three bypassed
// - all rates scale with the converter clock; no absolute timing used
// - stage two is an order-N moving sum of length B
// - fir mode uses a coefficient filter against 50 and 60 Hz lines
// - fir mode offers 2.5, 5, 10, 20 sps, settled in one conversion
// - fir takes the 600 Hz sinc stream and decimates by 30
// - first-order averager after fir gives 10, 5 and 2.5 sps
// - two modes: sinc mode and fir mode
// - input is the one-bit ones-density stream, filtered and decimated
`timescale 1ns/100ps
module sfd_filter
(
    input logic clk,
    input logic srst,
    input logic mod_bit,
    input sfd_pkg::sfd_cfg_t cfg,
    output logic res_valid,
    input logic res_ready,
    output sfd_pkg::sfd_word_t res_word,
    output logic res_overrun
);
    import sfd_pkg::*;

    logic mod_meta_r;
    logic mod_sync_r;
    sfd_cfg_t cfg_r;
    logic cfg_change;
    logic clr;
    logic fir_mode;
    logic bypass;
    logic [6:0] a_last;
    logic [12:0] b_val;
    logic [12:0] b_last;
    logic [3:0] b_sh;
    logic [2:0] ord;
    logic [1:0] ord_idx;
    logic [1:0] avg_sh;
    logic [6:0] sh_amt;
    logic [2:0] mod_cnt_r;
    logic mod_tick;

    // pin synchroniser
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mod_meta_r <= 1'b0;
            mod_sync_r <= 1'b0;
        end
        else
        begin
            mod_meta_r <= mod_bit;
            mod_sync_r <= mod_meta_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            cfg_r <= SFD_CFG_RST;
        else
            cfg_r <= cfg;
    end

    assign cfg_change = (cfg != cfg_r);
    assign clr = srst || cfg_change;

    // settings decode
    always_comb
    begin
        fir_mode = (cfg_r.mode == SFD_MODE_FIR);
        bypass = !fir_mode && (cfg_r.rate >= SFD_RATE_BYP64);
        if (cfg_r.rate == SFD_RATE_BYP24)
            a_last = SFD_A24_LAST;
        else if (cfg_r.rate == SFD_RATE_BYP48)
            a_last = SFD_A48_LAST;
        else
            a_last = SFD_A64_LAST;
        b_val = fir_mode ? SFD_B_FIR : SFD_B_TABLE[cfg_r.rate];
        b_sh = fir_mode ? SFD_SH_FIR : SFD_SH_TABLE[cfg_r.rate];
        if (cfg_r.order == 3'h0)
            ord = 3'h1;
        else if (cfg_r.order > 3'h4)
            ord = 3'h4;
        else
            ord = cfg_r.order;
        avg_sh = SFD_AVG_SH[cfg_r.rate];
    end

    assign b_last = b_val - 13'h0001;
    assign ord_idx = 2'(ord - 3'h1);
    assign sh_amt = 7'(ord * b_sh);

    // modulator sample divider
    always_ff @(posedge clk)
    begin
        if (clr)
            mod_cnt_r <= 3'h0;
        else
            mod_cnt_r <= mod_cnt_r + 3'h1;
    end

    assign mod_tick = (mod_cnt_r == SFD_MOD_DIV_LAST);

    // stage one: sinc5, decimation by a
    logic [SFD_S1_W-1:0] integ1 [0:SFD_S1_ORDER-1];
    logic [SFD_S1_W-1:0] dly1 [0:SFD_S1_ORDER-1];
    logic [SFD_S1_W-1:0] c1 [0:SFD_S1_ORDER];
    logic [6:0] s1_cnt_r;
    logic s1_tick;
    logic s1_valid_r;
    logic [SFD_S1_W-1:0] s1_out_r;

    assign s1_tick = mod_tick && (s1_cnt_r == a_last);
    assign c1[0] = integ1[SFD_S1_ORDER-1];

    genvar k;
    generate
        for (k = 0; k < SFD_S1_ORDER; k++)
        begin : g_s1
            logic [SFD_S1_W-1:0] src;
            if (k == 0)
            begin : g_first
                assign src = {{(SFD_S1_W-1){1'b0}}, mod_sync_r};
            end
            else
            begin : g_next
                assign src = integ1[k-1];
            end
            assign c1[k+1] = c1[k] - dly1[k];
            always_ff @(posedge clk)
            begin
                if (clr)
                begin
                    integ1[k] <= '0;
                    dly1[k] <= '0;
                end
                else
                begin
                    if (mod_tick)
                        integ1[k] <= integ1[k] + src;
                    if (s1_tick)
                        dly1[k] <= c1[k];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            s1_cnt_r <= 7'h00;
            s1_valid_r <= 1'b0;
            s1_out_r <= '0;
        end
        else
        begin
            if (mod_tick)
                s1_cnt_r <= (s1_cnt_r == a_last) ? 7'h00 : s1_cnt_r + 7'h01;
            s1_valid_r <= s1_tick;
            if (s1_tick)
                s1_out_r <= c1[SFD_S1_ORDER];
        end
    end

    // stage two: sinc order 1..4, decimation by b
    logic [SFD_S2_W-1:0] integ2 [0:SFD_S2_ORDER-1];
    logic [SFD_S2_W-1:0] dly2 [0:SFD_S2_ORDER-1];
    logic [SFD_S2_W-1:0] c2 [0:SFD_S2_ORDER];
    logic [SFD_S2_W+SFD_S2_IN_LSB-1:0] s2_scaled;
    logic [12:0] s2_cnt_r;
    logic s2_en;
    logic s2_tick;
    logic s2_valid_r;
    logic [SFD_OUT_W-1:0] s2_out_r;

    assign s2_en = s1_valid_r && !bypass;
    assign s2_tick = s2_en && (s2_cnt_r == b_last);
    assign c2[0] = integ2[ord_idx];
    assign s2_scaled = {c2[ord], {SFD_S2_IN_LSB{1'b0}}} >> sh_amt;

    generate
        for (k = 0; k < SFD_S2_ORDER; k++)
        begin : g_s2
            logic [SFD_S2_W-1:0] src;
            if (k == 0)
            begin : g_first
                assign src = {{(SFD_S2_W-SFD_S2_IN_W){1'b0}},
                              s1_out_r[SFD_S1_FS_MSB:SFD_S2_IN_LSB]};
            end
            else
            begin : g_next
                assign src = integ2[k-1];
            end
            assign c2[k+1] = c2[k] - dly2[k];
            always_ff @(posedge clk)
            begin
                if (clr)
                begin
                    integ2[k] <= '0;
                    dly2[k] <= '0;
                end
                else
                begin
                    if (s2_en)
                        integ2[k] <= integ2[k] + src;
                    if (s2_tick)
                        dly2[k] <= c2[k];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            s2_cnt_r <= 13'h0000;
            s2_valid_r <= 1'b0;
            s2_out_r <= '0;
        end
        else
        begin
            if (s2_en)
                s2_cnt_r <= (s2_cnt_r == b_last) ? 13'h0000 : s2_cnt_r + 13'h0001;
            s2_valid_r <= s2_tick;
            if (s2_tick)
                s2_out_r <= s2_scaled[SFD_OUT_W-1:0];
        end
    end

    // fir section: 30 taps on the 600 Hz stream, one output per 30 inputs
    logic fir_en;
    logic [4:0] fir_idx_r;
    logic signed [48:0] fir_prod;
    logic signed [55:0] fir_acc_r;
    logic signed [55:0] fir_sum;
    logic signed [55:0] fir_shf;
    logic fir_valid_r;
    logic [SFD_OUT_W-1:0] fir_out_r;

    assign fir_en = s2_valid_r && fir_mode;
    assign fir_prod = $signed({1'b0, s2_out_r}) * SFD_FIR_COEF[fir_idx_r];
    assign fir_sum = fir_acc_r + 56'(fir_prod);
    assign fir_shf = fir_sum >>> SFD_COEF_SH;

    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            fir_idx_r <= 5'h00;
            fir_acc_r <= '0;
            fir_valid_r <= 1'b0;
            fir_out_r <= '0;
        end
        else
        begin
            fir_valid_r <= fir_en && (fir_idx_r == SFD_FIR_LAST);
            if (fir_en)
            begin
                if (fir_idx_r == SFD_FIR_LAST)
                begin
                    fir_idx_r <= 5'h00;
                    fir_acc_r <= '0;
                    fir_out_r <= fir_shf[SFD_OUT_W-1:0];
                end
                else
                begin
                    fir_idx_r <= fir_idx_r + 5'h01;
                    fir_acc_r <= fir_sum;
                end
            end
        end
    end

    // first-order averager after the fir
    logic [2:0] avg_cnt_r;
    logic [2:0] avg_last;
    logic [34:0] avg_acc_r;
    logic [34:0] avg_sum;
    logic [34:0] avg_shf;
    logic avg_valid_r;
    logic [SFD_OUT_W-1:0] avg_out_r;

    assign avg_last = 3'((4'h1 << avg_sh) - 4'h1);
    assign avg_sum = avg_acc_r + {3'h0, fir_out_r};
    assign avg_shf = avg_sum >> avg_sh;

    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            avg_cnt_r <= 3'h0;
            avg_acc_r <= '0;
            avg_valid_r <= 1'b0;
            avg_out_r <= '0;
        end
        else
        begin
            avg_valid_r <= fir_valid_r && (avg_cnt_r == avg_last);
            if (fir_valid_r)
            begin
                if (avg_cnt_r == avg_last)
                begin
                    avg_cnt_r <= 3'h0;
                    avg_acc_r <= '0;
                    avg_out_r <= avg_shf[SFD_OUT_W-1:0];
                end
                else
                begin
                    avg_cnt_r <= avg_cnt_r + 3'h1;
                    avg_acc_r <= avg_sum;
                end
            end
        end
    end

    // result select and strobe
    logic sel_strobe;
    logic [SFD_OUT_W-1:0] sel_value;
    logic word_strobe_r;
    sfd_word_t word_r;
    logic buf_ready;

    always_comb
    begin
        if (bypass)
        begin
            sel_strobe = s1_valid_r;
            sel_value = s1_out_r;
        end
        else if (!fir_mode)
        begin
            sel_strobe = s2_valid_r;
            sel_value = s2_out_r;
        end
        else
        begin
            sel_strobe = avg_valid_r;
            sel_value = avg_out_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            word_strobe_r <= 1'b0;
            word_r <= '0;
        end
        else
        begin
            word_strobe_r <= sel_strobe;
            if (sel_strobe)
                word_r <= '{mode: cfg_r.mode, value: sel_value};
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            res_overrun <= 1'b0;
        else
            res_overrun <= word_strobe_r && !buf_ready;
    end

    sfd_buf2 u_buf
    (
        .clk(clk),
        .srst(srst),
        .in_valid(word_strobe_r),
        .in_ready(buf_ready),
        .in_word(word_r),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_word(res_word)
    );

    // assertion helpers: event counts between outputs
    logic [7:0] mod_since_r;
    logic [12:0] s1_since_r;
    logic [5:0] s2_since_r;
    logic [3:0] fir_since_r;

    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            mod_since_r <= 8'h00;
            s1_since_r <= 13'h0000;
            s2_since_r <= 6'h00;
            fir_since_r <= 4'h0;
        end
        else
        begin
            mod_since_r <= s1_valid_r ? 8'h00 : mod_since_r + {7'h00, mod_tick};
            s1_since_r <= s2_valid_r ? 13'h0000 : s1_since_r + {12'h000, s2_en};
            s2_since_r <= fir_valid_r ? 6'h00 : s2_since_r + {5'h00, fir_en};
            fir_since_r <= avg_valid_r ? 4'h0 : fir_since_r + {3'h0, fir_valid_r};
        end
    end

    AST_MOD_PERIOD: assert property (@(posedge clk) disable iff (srst || cfg_change)
        mod_tick |=> (!mod_tick)[*7] ##1 mod_tick)
        else $error("modulator sample spacing is not eight clocks");

    AST_S1_RATIO: assert property (@(posedge clk) disable iff (srst)
        s1_valid_r |-> mod_since_r == ({1'b0, a_last} + 8'h01))
        else $error("stage one decimation ratio wrong");

    AST_BYPASS_PATH: assert property (@(posedge clk) disable iff (srst)
        bypass && s1_valid_r && !cfg_change |=> word_strobe_r && word_r.value == $past(s1_out_r))
        else $error("bypass rate did not deliver stage one result");

    AST_B_RATIO: assert property (@(posedge clk) disable iff (srst)
        s2_valid_r |-> s1_since_r == b_val)
        else $error("stage two decimation ratio wrong");

    AST_STROBE_ONE: assert property (@(posedge clk) disable iff (srst)
        word_strobe_r |=> !word_strobe_r)
        else $error("output strobe longer than one cycle");

    AST_CLEAR: assert property (@(posedge clk) disable iff (srst)
        cfg_change |=> mod_cnt_r == 3'h0 && s1_cnt_r == 7'h00 && integ1[0] == '0
            && s2_cnt_r == 13'h0000 && fir_idx_r == 5'h00 && !word_strobe_r)
        else $error("settings change did not clear filter state");

    AST_FIR_DEC: assert property (@(posedge clk) disable iff (srst)
        fir_valid_r |-> s2_since_r == SFD_FIR_TAPS)
        else $error("fir did not decimate by thirty");

    AST_AVG_DEC: assert property (@(posedge clk) disable iff (srst)
        avg_valid_r |-> fir_since_r == (4'h1 << avg_sh))
        else $error("averager decimation wrong");
endmodule // sfd_filter

// ==== design/sfd_pkg.sv ====
// constants and types for the sinc/fir decimation filter
package sfd_pkg;
    typedef enum logic {SFD_MODE_SINC = 1'b0, SFD_MODE_FIR = 1'b1} sfd_mode_t;

    typedef struct packed {
        sfd_mode_t mode;
        logic [2:0] order;
        logic [3:0] rate;
    } sfd_cfg_t;

    typedef struct packed {
        sfd_mode_t mode;
        logic [31:0] value;
    } sfd_word_t;

    localparam sfd_cfg_t SFD_CFG_RST = '{mode: SFD_MODE_SINC, order: 3'h1, rate: 4'h0};

    // modulator sample every eighth converter clock
    localparam logic [2:0] SFD_MOD_DIV_LAST = 3'h7;

    localparam int SFD_S1_ORDER = 5;
    localparam int SFD_S1_W = 32;
    localparam int SFD_S2_ORDER = 4;
    localparam int SFD_S1_FS_MSB = 30;
    localparam int SFD_S2_IN_LSB = 5;
    localparam int SFD_S2_IN_W = SFD_S1_FS_MSB - SFD_S2_IN_LSB + 1;
    localparam int SFD_S2_W = SFD_S2_IN_W + 4 * 13;
    localparam int SFD_OUT_W = 32;

    localparam logic [6:0] SFD_A64_LAST = 7'h3F;
    localparam logic [6:0] SFD_A48_LAST = 7'h2F;
    localparam logic [6:0] SFD_A24_LAST = 7'h17;

    localparam logic [3:0] SFD_RATE_BYP64 = 4'hD;
    localparam logic [3:0] SFD_RATE_BYP48 = 4'hE;
    localparam logic [3:0] SFD_RATE_BYP24 = 4'hF;

    localparam logic [12:0] SFD_B_TABLE [16] = '{
        13'h1680, 13'h0B40, 13'h05A0, 13'h0360, 13'h02D0, 13'h0120, 13'h00F0, 13'h0090,
        13'h0024, 13'h000C, 13'h0006, 13'h0003, 13'h0002, 13'h0001, 13'h0001, 13'h0001};
    localparam logic [3:0] SFD_SH_TABLE [16] = '{
        4'hD, 4'hC, 4'hB, 4'hA, 4'hA, 4'h9, 4'h8, 4'h8,
        4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'h0, 4'h0};

    // fir pre-stage runs at 600 Hz: 14400 / 24
    localparam logic [12:0] SFD_B_FIR = 13'h0018;
    localparam logic [3:0] SFD_SH_FIR = 4'h5;

    localparam logic [4:0] SFD_FIR_LAST = 5'h1D;
    localparam logic [5:0] SFD_FIR_TAPS = 6'h1E;
    localparam int SFD_COEF_SH = 15;
    localparam logic signed [15:0] SFD_FIR_COEF [30] = '{default: 16'sh0444};

    // averager shift per rate code: 2.5, 5, 10 sps, all others 20 sps
    localparam logic [1:0] SFD_AVG_SH [16] = '{
        2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
endpackage

// ==== verification/sfd_far_model.sv ====
// far-side model: modulator bit source and conversion result consumer
`timescale 1ns/100ps
module sfd_far_model
(
    input logic clk,
    input logic [1:0] bit_mode,
    input logic [1:0] ready_mode,
    input logic [31:0] rnd,
    output logic mod_bit,
    input logic res_valid,
    output logic res_ready,
    input sfd_pkg::sfd_word_t res_word,
    output logic [15:0] got_cnt,
    output sfd_pkg::sfd_word_t got_word,
    output logic [31:0] got_gap
);
    import sfd_pkg::*;
    logic [31:0] cyc;
    logic [31:0] last_cyc;
    logic [2:0] bit_div;
    logic seen_valid;
    sfd_word_t seen_word;

    initial
    begin
        mod_bit = 1'b0;
        res_ready = 1'b0;
        seen_valid = 1'b0;
        seen_word = '0;
        got_cnt = 16'h0000;
        got_word = '0;
        got_gap = 32'h0;
        cyc = 32'h0;
        last_cyc = 32'h0;
        bit_div = 3'h0;
    end

    // random bits held eight clocks each, or a constant level
    always @(negedge clk)
    begin
        bit_div <= bit_div + 3'h1;
        if (bit_mode != 2'h2)
            mod_bit <= bit_mode[0];
        else if (bit_div == 3'h7)
            mod_bit <= rnd[1];
        res_ready <= (ready_mode == 2'h0) || ((ready_mode == 2'h2) && rnd[0]);
        // valid and word as they stand before the next rising edge
        seen_valid <= res_valid;
        seen_word <= res_word;
    end

    // take a word on the edge where valid and ready meet
    always @(posedge clk)
    begin
        cyc <= cyc + 32'h1;
        if (seen_valid === 1'b1 && res_ready === 1'b1)
        begin
            got_cnt <= got_cnt + 16'h1;
            got_word <= seen_word;
            got_gap <= cyc - last_cyc;
            last_cyc <= cyc;
        end
    end
endmodule // sfd_far_model

// ==== verification/tb.sv ====
// self-checking bench for the sinc/fir decimation filter
`timescale 1ns/100ps
module tb;
    import sfd_pkg::*;
    logic clk;
    logic srst;
    logic mod_bit;
    sfd_cfg_t cfg;
    logic res_valid;
    logic res_ready;
    sfd_word_t res_word;
    logic res_overrun;
    logic [1:0] bit_mode;
    logic [1:0] ready_mode;
    logic [31:0] rnd;
    logic [15:0] got_cnt;
    sfd_word_t got_word;
    logic [31:0] got_gap;
    int failures = 0;
    int check_count = 0;
    int ov_cnt = 0;

    sfd_filter u_sfd_filter (.clk(clk), .srst(srst), .mod_bit(mod_bit), .cfg(cfg),
        .res_valid(res_valid), .res_ready(res_ready), .res_word(res_word),
        .res_overrun(res_overrun));
    sfd_far_model u_sfd_far_model (.clk(clk), .bit_mode(bit_mode), .ready_mode(ready_mode),
        .rnd(rnd), .mod_bit(mod_bit), .res_valid(res_valid), .res_ready(res_ready),
        .res_word(res_word), .got_cnt(got_cnt), .got_word(got_word), .got_gap(got_gap));

    always #10 clk = ~clk;

    // sample the registered overrun pulse away from its launching edge
    always @(negedge clk)
    begin
        if (res_overrun === 1'b1)
            ov_cnt <= ov_cnt + 1;
    end

    function automatic logic [31:0] a_of(input logic [3:0] r);
        return (r == 4'hF) ? 32'h18 : ((r == 4'hE) ? 32'h30 : 32'h40);
    endfunction

    function automatic logic [31:0] period_of(input logic [3:0] r);
        logic [31:0] bt [16] = '{32'h1680, 32'hB40, 32'h5A0, 32'h360, 32'h2D0, 32'h120,
            32'hF0, 32'h90, 32'h24, 32'hC, 32'h6, 32'h3, 32'h2, 32'h1, 32'h1, 32'h1};
        return 32'h8 * a_of(r) * bt[r];
    endfunction

    function automatic logic [31:0] full_of(input logic [3:0] r);
        logic [31:0] a;
        a = a_of(r);
        return a * a * a * a * a;
    endfunction

    task automatic print_verdict();
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check_num(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input sfd_word_t exp, input sfd_word_t got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic next_word(input int limit);
        logic [15:0] start;
        int k;
        start = got_cnt;
        k = 0;
        while (got_cnt === start && k < limit)
        begin
            @(negedge clk);
            k++;
        end
        if (got_cnt === start)
        begin
            failures++;
            print_verdict();
        end
    endtask

    task automatic set_cfg(input sfd_mode_t m, input logic [2:0] o, input logic [3:0] r);
        @(negedge clk);
        cfg <= '{mode: m, order: o, rate: r};
    endtask

    task automatic run_bypass(input logic [3:0] r);
        set_cfg(SFD_MODE_SINC, 3'h1, r);
        bit_mode <= 2'h1;
        repeat (7) next_word(int'(period_of(r)) + 400);
        check_word("bypass word", '{SFD_MODE_SINC, full_of(r)}, got_word);
        next_word(int'(period_of(r)) + 400);
        check_num("bypass gap", period_of(r), got_gap);
    endtask

    task automatic run_sinc(input logic [3:0] r, input logic [2:0] o);
        set_cfg(SFD_MODE_SINC, o, r);
        bit_mode <= 2'h2;
        repeat (3) next_word(int'(period_of(r)) + 400);
        check_num("sinc gap", period_of(r), got_gap);
        check_num("sinc mode", 32'(SFD_MODE_SINC), 32'(got_word.mode));
    endtask

    initial
    begin
        int ov0;
        logic [15:0] cnt0;
        clk = 1'b0;
        srst = 1'b1;
        cfg = SFD_CFG_RST;
        bit_mode = 2'h0;
        ready_mode = 2'h0;
        rnd = 32'h0;
        void'($urandom(1));
        fork
            forever
            begin
                @(posedge clk);
                rnd <= $urandom;
            end
        join_none
        repeat (6) @(negedge clk);
        check_num("reset valid", 32'h0, {31'h0, res_valid});
        check_word("reset word", '0, res_word);
        srst <= 1'b0;
        // bypassed rates, full-scale input
        run_bypass(4'hF);
        run_bypass(4'hE);
        run_bypass(4'hD);
        // order change alone clears the filter: zeros in, zeros out
        @(negedge clk);
        cfg <= '{mode: SFD_MODE_SINC, order: 3'h2, rate: 4'hD};
        bit_mode <= 2'h0;
        repeat (3) @(negedge clk);
        repeat (3)
        begin
            next_word(700);
            check_word("cleared word", '{SFD_MODE_SINC, 32'h0}, got_word);
        end
        // second stage rates, each order once
        run_sinc(4'hC, 3'h4);
        run_sinc(4'hB, 3'h3);
        run_sinc(4'hA, 3'h2);
        run_sinc(4'h9, 3'h1);
        // receiver stall: two words held, third dropped
        set_cfg(SFD_MODE_SINC, 3'h1, 4'hF);
        bit_mode <= 2'h1;
        repeat (7) next_word(600);
        ov0 = ov_cnt;
        ready_mode <= 2'h1;
        repeat (600) @(negedge clk);
        check_num("held valid", 32'h1, {31'h0, res_valid});
        check_num("overruns", 32'h1, 32'(ov_cnt - ov0));
        ready_mode <= 2'h0;
        next_word(20);
        next_word(20);
        check_num("drain gap", 32'h1, got_gap);
        check_word("drained word", '{SFD_MODE_SINC, full_of(4'hF)}, got_word);
        // random bits with random stalls stay within full scale
        ready_mode <= 2'h2;
        bit_mode <= 2'h2;
        repeat (8)
        begin
            next_word(2000);
            check_num("in range", 32'h1, {31'h0, got_word.value <= full_of(4'hF)});
            check_num("word mode", 32'(SFD_MODE_SINC), 32'(got_word.mode));
        end
        check_num("no overrun", 32'h1, 32'(ov_cnt - ov0));
        // fir mode decimates far below the bypass rates
        ready_mode <= 2'h0;
        set_cfg(SFD_MODE_FIR, 3'h3, 4'h0);
        repeat (4) @(negedge clk);
        cnt0 = got_cnt;
        repeat (3000) @(negedge clk);
        check_num("fir words", 32'(cnt0), 32'(got_cnt));
        check_num("fir valid", 32'h0, {31'h0, res_valid});
        // reset in mid-run, then a fresh sinc word
        set_cfg(SFD_MODE_SINC, 3'h1, 4'hF);
        next_word(600);
        srst <= 1'b1;
        repeat (2) @(negedge clk);
        check_num("mid reset valid", 32'h0, {31'h0, res_valid});
        check_num("mid reset overrun", 32'h0, {31'h0, res_overrun});
        srst <= 1'b0;
        next_word(600);
        check_num("after reset mode", 32'(SFD_MODE_SINC), 32'(got_word.mode));
        print_verdict();
    end
endmodule // tb
